// ### rtc_i2c_consts.svh
// constants for the clock chip serial access block and its bus master
`ifndef RTC_I2C_CONSTS_SVH
`define RTC_I2C_CONSTS_SVH

// ----------------------------------------------------------------
// clock rate
// ----------------------------------------------------------------
`define CLK_HZ 25000000
`define CLK_MHZ 25

// ----------------------------------------------------------------
// bus format
// ----------------------------------------------------------------
`define DEV_ADDR 7'h32
`define PTR_DEFAULT 4'hF
`define FMT_WRITE 4'h0
`define FMT_READ_NOW 4'h4
`define BYTE_LAST_BIT 4'h7
`define ACK_SLOT 4'h8
`define IDLE_BYTE 8'hFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCL_HZ 100000
`define SCL_QTR (`CLK_HZ / (`SCL_HZ * 4))
`define TIMEOUT_MS 500
`define TIMEOUT_CYC ((`CLK_HZ / 1000) * `TIMEOUT_MS)
`define BUS_FREE_NS 61000
`define BUS_FREE_CYC ((`BUS_FREE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### rtc_i2c_pkg.sv
// types shared by the serial access block and its bus master
package rtc_i2c_pkg;

  // ----------------------------------------------------------------
  // device states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_ADDR,
    DEV_CTRL,
    DEV_WDATA,
    DEV_RDATA,
    DEV_IGNORE
  } dev_state_t;

  // ----------------------------------------------------------------
  // master states and commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HST_IDLE,
    HST_START,
    HST_BIT,
    HST_STOP
  } host_state_t;

  typedef enum logic [1:0] {
    CMD_START,
    CMD_WRITE,
    CMD_READ,
    CMD_STOP
  } cmd_t;

endpackage

// ### rtc_link_if.sv
// two-wire link between bus master and clock chip, with pulled-up data line
`timescale 1ns/1ps
`default_nettype none

interface rtc_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;

  // open drain: any enabled low wins, otherwise the pull-up
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

  modport master (
    output scl,
    output sda_m_o,
    output sda_m_oe,
    input sda
  );

  modport slave (
    input scl,
    input sda,
    output sda_s_o,
    output sda_s_oe
  );
endinterface

`default_nettype wire

// ### rtc_i2c_host.sv
// bus master end: byte level commands to clock line and open-drain data
`timescale 1ns/1ps
`default_nettype none
`include "rtc_i2c_consts.svh"

module rtc_i2c_host (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // link
  rtc_link_if.master link,
  // command
  input wire logic cmd_valid,
  input wire rtc_i2c_pkg::cmd_t cmd_code,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  output logic cmd_ready,
  // response
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  import rtc_i2c_pkg::*;

  localparam int QTR = `SCL_QTR;
  localparam int GAP = `BUS_FREE_CYC;

  host_state_t st_q;
  logic [7:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic rd_q;
  logic nack_q;
  logic [10:0] gap_q;
  logic scl_q;
  logic oe_q;
  logic o_q;
  logic sda_s1;
  logic sda_s2;
  logic tick;
  logic take;

  assign link.scl = scl_q;
  assign link.sda_m_oe = oe_q;
  assign link.sda_m_o = o_q;
  assign tick = (div_q == 8'(QTR - 1));
  assign take = cmd_valid && cmd_ready;

  // ----------------------------------------------------------------
  // data line input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    sda_s1 <= link.sda;
    sda_s2 <= sda_s1;
  end

  // ----------------------------------------------------------------
  // quarter bit divider
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst || st_q == HST_IDLE || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // bus free time after a stop
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      gap_q <= 11'h000;
    end else if (st_q == HST_STOP && tick && ph_q == 2'h3) begin
      gap_q <= 11'(GAP);
    end else if (gap_q != 11'h000) begin
      gap_q <= gap_q - 11'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= (st_q == HST_IDLE) && !take && (gap_q == 11'h000);
    end
  end

  // ----------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_q <= HST_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      o_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (st_q)
        HST_IDLE: begin
          ph_q <= 2'h0;
          bit_q <= 4'h0;
          if (take) begin
            sh_q <= cmd_data;
            rd_q <= (cmd_code == CMD_READ);
            nack_q <= cmd_nack;
            unique case (cmd_code)
              CMD_START: st_q <= HST_START;
              CMD_WRITE, CMD_READ: st_q <= HST_BIT;
              CMD_STOP: st_q <= HST_STOP;
            endcase
          end
        end
        HST_START: if (tick) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: oe_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: oe_q <= 1'b1;
            2'h3: begin
              scl_q <= 1'b0;
              st_q <= HST_IDLE;
            end
          endcase
        end
        HST_BIT: if (tick) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: begin
              if (bit_q < `ACK_SLOT) begin
                oe_q <= !rd_q && !sh_q[7];
              end else begin
                oe_q <= rd_q && !nack_q;
              end
            end
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (bit_q < `ACK_SLOT) begin
                sh_q <= {sh_q[6:0], sda_s2};
              end else begin
                rsp_ack <= !sda_s2;
              end
            end
            2'h3: begin
              scl_q <= 1'b0;
              if (bit_q == `ACK_SLOT) begin
                oe_q <= 1'b0;
                st_q <= HST_IDLE;
                rsp_valid <= 1'b1;
                rsp_data <= sh_q;
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end
          endcase
        end
        HST_STOP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: oe_q <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: oe_q <= 1'b0;
            2'h3: st_q <= HST_IDLE;
          endcase
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// ### rtc_i2c_device.sv
// clock chip end: serial slave access, carry hold and access timeout
`timescale 1ns/1ps
`default_nettype none
`include "rtc_i2c_consts.svh"

// Notes on behaviour
// - data falling while clock high starts access
// - data rising while clock high ends access
// - only master makes start, stop; idle high
// - eight-bit units, each acknowledged by receiver
// - receiver drives ack low, releases after ninth
// - master withholds last ack; slave keeps released
// - first byte is address then direction bit
// - answer only to address 0110010
// - start without stop is repeated start
// - second write byte: pointer then format
// - third byte stored at pointer, then increments
// - stop loads pointer with Fh
// - read method one: pointer write, repeated start
// - format 4h: transmit right after pointer byte
// - read after address starts at pointer Fh
// - carries held during access, applied after stop
// - access ends after half second timeout
// - repeated start keeps the timeout running
// - after timeout: no write ack, reads FFh
// - master finishes access within half second
// - master waits 61us after stop before start
// - data line is open drain only
module rtc_i2c_device #(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
  // clocks and reset
  input wire logic link_clk,
  input wire logic clock,
  input wire logic nrst,
  // link
  rtc_link_if.slave link,
  // register file, link clock domain
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  input wire logic [7:0] reg_rdata,
  // timekeeping, clock domain
  output logic carry_hold
);
  import rtc_i2c_pkg::*;

  dev_state_t st_q;
  logic lrst_s1;
  logic lrst_n;
  logic scl_s1;
  logic scl_s2;
  logic scl_d;
  logic sda_s1;
  logic sda_s2;
  logic sda_d;
  logic start_c;
  logic stop_c;
  logic rise;
  logic fall;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic rd_q;
  logic fmt_rd_q;
  logic active_q;
  logic tout_q;
  logic stgl_q;
  logic oe_q;
  logic o_q;
  logic to_s1;
  logic to_s2;
  logic to_s3;
  logic to_evt;
  logic hold_s1;
  logic hold_s3;
  logic st_s1;
  logic st_s2;
  logic st_s3;
  logic armed_q;
  logic to_tgl_q;
  logic [23:0] tmr_q;
  logic [3:0] reg_addr_q_w;

  assign link.sda_s_oe = oe_q;
  assign link.sda_s_o = o_q;
  assign reg_addr = reg_addr_q_w;

  // ----------------------------------------------------------------
  // link domain reset and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    lrst_s1 <= nrst;
    lrst_n <= lrst_s1;
  end

  always_ff @(posedge link_clk) begin
    scl_s1 <= link.scl;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= link.sda;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
  end

  assign start_c = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_c = scl_s2 && scl_d && !sda_d && sda_s2;
  assign rise = scl_s2 && !scl_d;
  assign fall = !scl_s2 && scl_d;

  // ----------------------------------------------------------------
  // timeout event from the clock domain
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    to_s1 <= to_tgl_q;
    to_s2 <= to_s1;
    to_s3 <= to_s2;
  end

  assign to_evt = to_s2 ^ to_s3;

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      st_q <= DEV_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= `IDLE_BYTE;
      rd_q <= 1'b0;
      fmt_rd_q <= 1'b0;
      active_q <= 1'b0;
      tout_q <= 1'b0;
      stgl_q <= 1'b0;
      oe_q <= 1'b0;
      o_q <= 1'b0;
      reg_addr_q_w <= `PTR_DEFAULT;
      reg_wdata <= 8'h00;
      reg_we <= 1'b0;
    end else begin
      reg_we <= 1'b0;
      if (start_c) begin
        st_q <= DEV_ADDR;
        bit_q <= 4'hF; // clock fall closing the start wraps to bit zero
        oe_q <= 1'b0;
        if (!active_q && !tout_q) begin
          active_q <= 1'b1;
          stgl_q <= ~stgl_q;
        end
      end else if (stop_c) begin
        st_q <= DEV_IDLE;
        bit_q <= 4'h0;
        oe_q <= 1'b0;
        active_q <= 1'b0;
        tout_q <= 1'b0;
        reg_addr_q_w <= `PTR_DEFAULT;
      end else if (st_q != DEV_IDLE && st_q != DEV_IGNORE) begin
        if (rise && bit_q < `ACK_SLOT) begin
          sh_q <= {sh_q[6:0], sda_s2};
        end
        if (rise && bit_q == `ACK_SLOT && st_q == DEV_RDATA) begin
          if (!sda_s2) begin
            reg_addr_q_w <= reg_addr_q_w + 4'h1;
          end else begin
            st_q <= DEV_IGNORE;
          end
        end
        if (fall) begin
          bit_q <= (bit_q == `ACK_SLOT) ? 4'h0 : bit_q + 4'h1;
          if (bit_q == `BYTE_LAST_BIT) begin
            oe_q <= 1'b0;
            unique case (st_q)
              DEV_ADDR: begin
                if (sh_q[7:1] == `DEV_ADDR) begin
                  oe_q <= 1'b1;
                  rd_q <= sh_q[0];
                end else begin
                  st_q <= DEV_IGNORE;
                end
              end
              DEV_CTRL: if (!tout_q) begin
                oe_q <= 1'b1;
                reg_addr_q_w <= sh_q[7:4];
                fmt_rd_q <= (sh_q[3:0] == `FMT_READ_NOW);
              end
              DEV_WDATA: if (!tout_q) begin
                oe_q <= 1'b1;
                reg_we <= 1'b1;
                reg_wdata <= sh_q;
              end
              DEV_RDATA: oe_q <= 1'b0;
              default: oe_q <= 1'b0;
            endcase
          end else if (bit_q == `ACK_SLOT) begin
            oe_q <= 1'b0;
            unique case (st_q)
              DEV_ADDR: begin
                st_q <= rd_q ? DEV_RDATA : DEV_CTRL;
                if (rd_q) begin
                  tx_q <= tout_q ? `IDLE_BYTE : reg_rdata;
                  oe_q <= !tout_q && !reg_rdata[7];
                end
              end
              DEV_CTRL: begin
                st_q <= fmt_rd_q ? DEV_RDATA : DEV_WDATA;
                if (fmt_rd_q) begin
                  tx_q <= tout_q ? `IDLE_BYTE : reg_rdata;
                  oe_q <= !tout_q && !reg_rdata[7];
                end
              end
              DEV_WDATA: if (!tout_q) begin
                reg_addr_q_w <= reg_addr_q_w + 4'h1;
              end
              DEV_RDATA: begin
                tx_q <= tout_q ? `IDLE_BYTE : reg_rdata;
                oe_q <= !tout_q && !reg_rdata[7];
              end
              default: oe_q <= 1'b0;
            endcase
          end else if (st_q == DEV_RDATA) begin
            tx_q <= {tx_q[6:0], 1'b1};
            oe_q <= !tx_q[6];
          end
        end
      end
      if (to_evt && !stop_c) begin
        tout_q <= 1'b1;
        tx_q <= `IDLE_BYTE;
        if (st_q == DEV_RDATA && !scl_s2) oe_q <= 1'b0;
        active_q <= 1'b0;
        reg_addr_q_w <= `PTR_DEFAULT;
      end
    end
  end

  // ----------------------------------------------------------------
  // clock domain: access level and start event crossings
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    hold_s1 <= active_q;
    carry_hold <= hold_s1;
    hold_s3 <= carry_hold;
    st_s1 <= stgl_q;
    st_s2 <= st_s1;
    st_s3 <= st_s2;
  end

  // ----------------------------------------------------------------
  // access timeout from the first start
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      armed_q <= 1'b0;
      tmr_q <= 24'h000000;
      to_tgl_q <= 1'b0;
    end else if (st_s2 ^ st_s3) begin
      armed_q <= 1'b1;
      tmr_q <= 24'h000000;
    end else if (armed_q && hold_s3 && !carry_hold) begin
      armed_q <= 1'b0;
    end else if (armed_q && tmr_q == 24'(TIMEOUT_CYCLES - 1)) begin
      armed_q <= 1'b0;
      to_tgl_q <= ~to_tgl_q;
    end else if (armed_q) begin
      tmr_q <= tmr_q + 24'h000001;
    end
  end
endmodule

`default_nettype wire

// ### rtc_i2c_props.sv
// assertions on the two-wire link and the carry hold
`timescale 1ns/1ps
`default_nettype none

module rtc_i2c_props #(
  parameter int TIMEOUT_CYCLES = 2000
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // link
  input wire logic scl,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic sda,
  // timekeeping
  input wire logic carry_hold
);
  logic scl_q;
  logic sda_q;
  logic idle_q;
  logic start_w;
  logic stop_w;
  int unsigned tcnt_q;
  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w = scl && scl_q && !sda_q && sda;
  always_ff @(posedge clock) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  always_ff @(posedge clock) begin
    if (!nrst || stop_w) begin
      idle_q <= 1'b1;
    end else if (start_w) begin
      idle_q <= 1'b0;
    end
  end
  // cycles since the first start of an access
  always_ff @(posedge clock) begin
    if (!nrst || stop_w) begin
      tcnt_q <= 0;
    end else if (start_w && idle_q) begin
      tcnt_q <= 1;
    end else if (tcnt_q != 0 && tcnt_q < TIMEOUT_CYCLES + 100) begin
      tcnt_q <= tcnt_q + 1;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  a_slave_pull_only: assert property (sda_s_oe |-> !sda_s_o)
    else $error("device drives data line high");
  a_master_pull_only: assert property (sda_m_oe |-> !sda_m_o)
    else $error("master drives data line high");
  a_start_by_master: assert property (start_w |-> sda_m_oe && !sda_s_oe)
    else $error("start not made by master alone");
  a_ack_drive_low: assert property ($rose(sda_s_oe) |-> !scl ##1 !scl)
    else $error("device pulls data while clock high");
  a_ack_release_low: assert property ($fell(sda_s_oe) |-> !scl)
    else $error("device releases data while clock high");
  a_idle_released: assert property (idle_q |-> !sda_s_oe)
    else $error("device drives idle bus");
  a_hold_on_start: assert property (start_w && idle_q |-> ##[1:8] carry_hold)
    else $error("carry hold missing after start");
  a_hold_off_stop: assert property (stop_w |-> ##[1:8] !carry_hold)
    else $error("carry hold kept after stop");
  a_timeout_ends: assert property (tcnt_q == TIMEOUT_CYCLES + 64 |-> !carry_hold)
    else $error("access not ended by timeout");
  a_no_early_end: assert property ($fell(carry_hold) |-> idle_q || tcnt_q >= TIMEOUT_CYCLES)
    else $error("access ended too early");
  c_timeout: cover property (tcnt_q == TIMEOUT_CYCLES + 64);
  c_ack: cover property ($rose(sda_s_oe));
  c_rep_start: cover property (start_w && !idle_q);
endmodule

`default_nettype wire

// ### rtc_i2c_slave_access_tb.sv
// bench joining the bus master and the clock chip over the link
`timescale 1ns/1ps
`default_nettype none
`include "rtc_i2c_consts.svh"

module rtc_i2c_slave_access_tb;
  import rtc_i2c_pkg::*;
  localparam int TO_CYC = 20000;
  localparam logic [7:0] WR_ADR = {`DEV_ADDR, 1'b0};
  localparam logic [7:0] RD_ADR = {`DEV_ADDR, 1'b1};
  logic clock, link_clk, nrst, cmd_valid, cmd_nack, cmd_ready, rsp_valid, rsp_ack;
  logic reg_we, carry_hold;
  logic [7:0] cmd_data, rsp_data, reg_wdata, reg_rdata;
  logic [3:0] reg_addr;
  cmd_t cmd_code;
  logic [7:0] regs [16];
  logic [7:0] mem [16];
  int error_cnt, n_checks, cyc, t0;
  rtc_link_if rtc_link_if_i ();
  rtc_i2c_host rtc_i2c_host_i (.clock(clock), .nrst(nrst), .link(rtc_link_if_i.master),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  rtc_i2c_device #(.TIMEOUT_CYCLES(TO_CYC)) rtc_i2c_device_i (.link_clk(link_clk),
    .clock(clock), .nrst(nrst), .link(rtc_link_if_i.slave), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata), .carry_hold(carry_hold));
  rtc_i2c_props #(.TIMEOUT_CYCLES(TO_CYC)) rtc_i2c_props_i (.clock(clock), .nrst(nrst),
    .scl(rtc_link_if_i.scl), .sda_m_o(rtc_link_if_i.sda_m_o), .sda_m_oe(rtc_link_if_i.sda_m_oe),
    .sda_s_o(rtc_link_if_i.sda_s_o), .sda_s_oe(rtc_link_if_i.sda_s_oe),
    .sda(rtc_link_if_i.sda), .carry_hold(carry_hold));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge clock) cyc <= cyc + 1;
  // register file behind the device
  always @(posedge link_clk) if (reg_we) regs[reg_addr] <= reg_wdata;
  assign reg_rdata = regs[reg_addr];
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // bounded wait for command ready (sel 0) or response (sel 1)
  task automatic wait_sig(input bit sel);
    int i;
    i = 0;
    while ((sel ? rsp_valid : cmd_ready) !== 1'b1 && i < 5000) begin
      @(posedge clock);
      #1;
      i++;
    end
    if (i == 5000) begin
      error_cnt++;
      $display("wrong value at %0t: handshake missing", $time);
      give_verdict();
    end
  endtask
  task automatic do_cmd(input cmd_t c, input logic [7:0] d, input logic nk);
    wait_sig(1'b0);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    cmd_nack = nk;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    if (c == CMD_WRITE || c == CMD_READ) wait_sig(1'b1);
  endtask
  task automatic begin_acc();
    do_cmd(CMD_START, 8'h00, 1'b0);
  endtask
  task automatic stop_wait();
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    wait_sig(1'b0);
    check({7'h00, carry_hold}, 8'h00);
    check({6'h00, rtc_link_if_i.scl, rtc_link_if_i.sda}, 8'h03);
  endtask
  task automatic wr(input logic [7:0] d, input logic ak);
    do_cmd(CMD_WRITE, d, 1'b0);
    check({7'h00, rsp_ack}, {7'h00, ak});
  endtask
  task automatic rd(input logic [7:0] exp, input logic nk);
    do_cmd(CMD_READ, 8'h00, nk);
    check(rsp_data, exp);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    cmd_valid = 1'b0;
    cmd_code = CMD_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    nrst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      regs[i] = {i[3:0], ~i[3:0]};
      mem[i] = regs[i];
    end
    repeat (5) @(posedge clock);
    #1;
    nrst = 1'b1;
    // write E, F, 0 across the pointer wrap
    begin_acc();
    wr(WR_ADR, 1'b1);
    wr(8'hE0, 1'b1);
    check({7'h00, carry_hold}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      mem[4'(k + 14)] = 8'h5A ^ 8'(k);
      wr(mem[4'(k + 14)], 1'b1);
    end
    stop_wait();
    // read from the default pointer
    begin_acc();
    wr(RD_ADR, 1'b1);
    rd(mem[15], 1'b0);
    rd(mem[0], 1'b0);
    rd(mem[1], 1'b1);
    check({7'h00, carry_hold}, 8'h01);
    stop_wait();
    // format 4h sends data right after the pointer byte
    begin_acc();
    wr(WR_ADR, 1'b1);
    wr(8'hE4, 1'b1);
    rd(mem[14], 1'b0);
    rd(mem[15], 1'b1);
    stop_wait();
    // pointer write, repeated start, read
    begin_acc();
    wr(WR_ADR, 1'b1);
    wr(8'h20, 1'b1);
    begin_acc();
    wr(RD_ADR, 1'b1);
    rd(mem[2], 1'b0);
    rd(mem[3], 1'b1);
    stop_wait();
    // foreign addresses are ignored
    for (int k = 0; k < 2; k++) begin
      begin_acc();
      wr(k ? 8'hE4 : 8'h66, 1'b0);
      wr(8'h00, 1'b0);
      stop_wait();
    end
    // timeout ends the access despite a repeated start
    t0 = cyc;
    begin_acc();
    wr(WR_ADR, 1'b1);
    repeat (3000) @(posedge clock);
    #1;
    begin_acc();
    wr(RD_ADR, 1'b1);
    while (cyc - t0 < TO_CYC + 400) @(posedge clock);
    #1;
    check({7'h00, carry_hold}, 8'h00);
    rd(8'hFF, 1'b1);
    begin_acc();
    wr(WR_ADR, 1'b1);
    wr(8'h30, 1'b0);
    wr(8'h99, 1'b0);
    stop_wait();
    for (int i = 0; i < 16; i++) check(regs[i], mem[i]);
    give_verdict();
  end
endmodule

`default_nettype wire
